//--- hdl/iprt_pkg.sv
package iprt_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned IPRT_DATA_W = 16;
  localparam int unsigned IPRT_CNT_W  = 5;

  // ----------------------------------------------------------------
  // Slowest programmed-I/O mode timing, in clocks
  // ----------------------------------------------------------------
  localparam logic [IPRT_CNT_W-1:0] IPRT_SAMPLE_CLKS = 5'h06;
  localparam logic [IPRT_CNT_W-1:0] IPRT_RECOV_CLKS  = 5'h0E;
  localparam logic [IPRT_CNT_W-1:0] IPRT_CNT_START   = 5'h01;

  // Resulting cycle with no drive wait states: 20 clocks
  localparam int unsigned IPRT_CYCLE_NS_30MHZ = 660;
  localparam int unsigned IPRT_CYCLE_NS_33MHZ = 600;
  localparam int unsigned IPRT_CYCLE_CLKS     = IPRT_SAMPLE_CLKS + IPRT_RECOV_CLKS;

  // ----------------------------------------------------------------
  // Channel select and strobe levels
  // ----------------------------------------------------------------
  localparam logic IPRT_CHAN_PRI   = 1'h0;
  localparam logic IPRT_CHAN_SEC   = 1'h1;
  localparam logic IPRT_STROBE_ON  = 1'h0;
  localparam logic IPRT_STROBE_OFF = 1'h1;

  typedef enum logic [1:0] {
    IPRT_IDLE,
    IPRT_ACTIVE,
    IPRT_RECOVER,
    IPRT_RESPOND
  } iprt_state_e;

endpackage : iprt_pkg

//--- hdl/iprt_skid_buf.sv
`timescale 1ns/1ps
module iprt_skid_buf #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wptr_r, wptr_nxt;
  logic [PW-1:0]    rptr_r, rptr_nxt;
  logic [CW-1:0]    cnt_r, cnt_nxt;
  logic             ready_r, ready_nxt;
  logic             push, pop;

  // ----------------------------------------------------------------
  // Pointers and occupancy
  // ----------------------------------------------------------------
  always_comb begin
    push     = in_valid && ready_r;
    pop      = out_valid && out_ready;
    wptr_nxt = wptr_r;
    rptr_nxt = rptr_r;
    if (push) begin
      wptr_nxt = (wptr_r == PW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
    end
    if (pop) begin
      rptr_nxt = (rptr_r == PW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
    end
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    // Ready is a flop so the source never sees a combinational path
    ready_nxt = (cnt_nxt != CW'(DEPTH));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
      ready_r <= 1'b1;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      cnt_r  <= cnt_nxt;
      ready_r <= ready_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (push && (wptr_r == PW'(i))) begin
        mem_r[i] <= in_data;
      end
    end
  end

  assign in_ready  = ready_r;
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rptr_r];

endmodule : iprt_skid_buf

//--- hdl/iprt_top.sv
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Ready sampled high: finish the data cycle with no extra wait states.
// [RULE2] A drive needing more time pulls its channel ready line low.
// [RULE3] A drive holding ready low keeps it low at least 48 ns.
// [RULE4] Slowest mode samples the ready input six clocks into the cycle.
// [RULE5] Slowest mode holds a fourteen clock recovery interval before the next cycle.
// [RULE6] Slowest mode cycle totals twenty clocks when the drive adds no waits.
// [RULE7] Ready low at sample point extends the strobe clock by clock until high.
module iprt_top
  import iprt_pkg::*;
#(
  parameter int unsigned                   DATA_W       = iprt_pkg::IPRT_DATA_W,
  parameter logic [IPRT_CNT_W-1:0]         SAMPLE_CLKS  = iprt_pkg::IPRT_SAMPLE_CLKS,
  parameter logic [IPRT_CNT_W-1:0]         RECOV_CLKS   = iprt_pkg::IPRT_RECOV_CLKS
) (
  // Clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RST,
  // Request stream
  input  wire logic              REQ_VALID,
  output logic                   REQ_READY,
  input  wire logic              REQ_WRITE,
  input  wire logic              REQ_CHAN,
  input  wire logic [DATA_W-1:0] REQ_DATA,
  // Response stream
  output logic                   RSP_VALID,
  input  wire logic              RSP_READY,
  output logic                   RSP_CHAN,
  output logic [DATA_W-1:0]      RSP_DATA,
  // Drive ready inputs
  input  wire logic              PRIMARY_CHANNEL_READY,
  input  wire logic              SECONDARY_CHANNEL_READY,
  // Strobes, one bit per channel, active low
  output logic [1:0]             READ_STROBE_N,
  output logic [1:0]             WRITE_STROBE_N,
  // Shared data bus
  input  wire logic [DATA_W-1:0] DATA_IN,
  output logic [DATA_W-1:0]      DATA_OUT,
  output logic                   DATA_OE_N
);

  import iprt_pkg::*;

  localparam int unsigned BW  = DATA_W + 2;
  localparam int unsigned NCH = 2;

  logic              buf_valid;
  logic              buf_ready;
  logic [BW-1:0]     buf_data;
  logic              cur_write, cur_chan;
  logic [DATA_W-1:0] cur_data;
  logic              ready_now;
  logic [NCH-1:0]    chan_rdy;
  logic [NCH-1:0]    chan_hit;

  iprt_state_e             state_r, state_nxt;
  logic [IPRT_CNT_W-1:0]   cnt_r, cnt_nxt;
  logic                    write_r, write_nxt;
  logic                    chan_r, chan_nxt;
  logic [DATA_W-1:0]       data_r, data_nxt;
  logic [1:0]              rd_n_r, rd_n_nxt;
  logic [1:0]              wr_n_r, wr_n_nxt;
  logic                    oe_n_r, oe_n_nxt;
  logic                    rsp_valid_r, rsp_valid_nxt;
  logic                    rsp_chan_r, rsp_chan_nxt;
  logic [DATA_W-1:0]       rsp_data_r, rsp_data_nxt;

  // ----------------------------------------------------------------
  // Request buffer
  // ----------------------------------------------------------------
  // Holds requests while a slow drive stretches the cycle
  iprt_skid_buf #(
    .WIDTH (BW),
    .DEPTH (2)
  ) u_buf (
    .clk       (CLOCK),
    .rst       (RST),
    .in_valid  (REQ_VALID),
    .in_ready  (REQ_READY),
    .in_data   ({REQ_WRITE, REQ_CHAN, REQ_DATA}),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data)
  );

  assign {cur_write, cur_chan, cur_data} = buf_data;
  assign buf_ready = (state_r == IPRT_IDLE);

  // ----------------------------------------------------------------
  // Per-channel ready select
  // ----------------------------------------------------------------
  // Only the channel that owns the cycle may stretch it
  assign chan_rdy = {SECONDARY_CHANNEL_READY, PRIMARY_CHANNEL_READY};
  for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
    assign chan_hit[ch] = (chan_r == 1'(ch)) && chan_rdy[ch];
  end
  assign ready_now = |chan_hit;

  // ----------------------------------------------------------------
  // Cycle timing engine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    write_nxt     = write_r;
    chan_nxt      = chan_r;
    data_nxt      = data_r;
    rd_n_nxt      = rd_n_r;
    wr_n_nxt      = wr_n_r;
    oe_n_nxt      = oe_n_r;
    rsp_valid_nxt = rsp_valid_r;
    case (state_r)
      IPRT_IDLE: begin
        if (buf_valid) begin
          write_nxt = cur_write;
          chan_nxt  = cur_chan;
          data_nxt  = cur_data;
          cnt_nxt   = IPRT_CNT_START;
          if (cur_write) begin
            wr_n_nxt[cur_chan] = IPRT_STROBE_ON;
            oe_n_nxt           = 1'b0;
          end else begin
            rd_n_nxt[cur_chan] = IPRT_STROBE_ON;
          end
          state_nxt = IPRT_ACTIVE;
        end
      end
      IPRT_ACTIVE: begin
        // [RULE4] Sample point check
        if (cnt_r != SAMPLE_CLKS) begin
          cnt_nxt = cnt_r + 1'b1;
        end else if (ready_now) begin
          // [RULE1] No extra waits
          rd_n_nxt  = {2{IPRT_STROBE_OFF}};
          wr_n_nxt  = {2{IPRT_STROBE_OFF}};
          oe_n_nxt  = 1'b1;
          if (!write_r) begin
            data_nxt = DATA_IN;
          end
          cnt_nxt   = IPRT_CNT_START;
          state_nxt = IPRT_RECOVER;
        end else begin
          // [RULE7] Strobe held while low
          // [RULE2] Drive-inserted waits
          state_nxt = IPRT_ACTIVE;
        end
      end
      IPRT_RECOVER: begin
        // [RULE5] Recovery count
        // [RULE6] Sample plus recovery
        if (cnt_r != RECOV_CLKS) begin
          cnt_nxt = cnt_r + 1'b1;
        end else begin
          rsp_valid_nxt = 1'b1;
          state_nxt     = IPRT_RESPOND;
        end
      end
      IPRT_RESPOND: begin
        // Engine stalls here so a slow consumer loses no answer
        if (RSP_READY) begin
          rsp_valid_nxt = 1'b0;
          state_nxt     = IPRT_IDLE;
        end
      end
      default: begin
        state_nxt = IPRT_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_r     <= IPRT_IDLE;
      cnt_r       <= '0;
      write_r     <= 1'b0;
      chan_r      <= IPRT_CHAN_PRI;
      data_r      <= '0;
      rd_n_r      <= {2{IPRT_STROBE_OFF}};
      wr_n_r      <= {2{IPRT_STROBE_OFF}};
      oe_n_r      <= 1'b1;
      rsp_valid_r <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      write_r     <= write_nxt;
      chan_r      <= chan_nxt;
      data_r      <= data_nxt;
      rd_n_r      <= rd_n_nxt;
      wr_n_r      <= wr_n_nxt;
      oe_n_r      <= oe_n_nxt;
      rsp_valid_r <= rsp_valid_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign READ_STROBE_N  = rd_n_r;
  assign WRITE_STROBE_N = wr_n_r;
  assign DATA_OUT       = data_r;
  assign DATA_OE_N      = oe_n_r;
  assign RSP_VALID      = rsp_valid_r;
  assign RSP_CHAN       = rsp_chan_r;
  assign RSP_DATA       = rsp_data_r;

  // ----------------------------------------------------------------
  // Response hold registers
  // ----------------------------------------------------------------
  // Own copy so the answer stays put while the engine state moves on
  always_comb begin
    rsp_chan_nxt = rsp_chan_r;
    rsp_data_nxt = rsp_data_r;
    if (rsp_valid_nxt && !rsp_valid_r) begin
      rsp_chan_nxt = chan_r;
      rsp_data_nxt = data_r;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rsp_chan_r <= IPRT_CHAN_PRI;
      rsp_data_r <= '0;
    end else begin
      rsp_chan_r <= rsp_chan_nxt;
      rsp_data_r <= rsp_data_nxt;
    end
  end

endmodule : iprt_top

//--- sim/iprt_drive_model.sv
`timescale 1ns/1ps
module iprt_drive_model (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [1:0]  read_strobe_n,
  input wire logic [1:0]  write_strobe_n,
  input wire logic [7:0]  wait_clks,
  output logic            pri_rdy,
  output logic            sec_rdy,
  output logic [15:0]     data_in
);
  logic [7:0]  cnt_r;
  logic        chan_r;
  logic        on_r;
  logic [15:0] noise_r;
  wire on = ~&{read_strobe_n, write_strobe_n};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {cnt_r, chan_r, on_r} <= '0;
      noise_r <= 16'h0000;
    end else begin
      on_r <= on;
      noise_r <= noise_r + 16'h9E37;
      if (on && !on_r && wait_clks != 8'h00) begin
        cnt_r <= (wait_clks < 8'h0C) ? 8'h0C : wait_clks;
        chan_r <= read_strobe_n[0] & write_strobe_n[0];
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
  // Pull-ups hold ready high when not pulled low
  assign pri_rdy = !(cnt_r != 8'h00 && !chan_r);
  assign sec_rdy = !(cnt_r != 8'h00 && chan_r);
  // Undriven bus keeps changing so stale values cannot pass
  assign data_in = !read_strobe_n[0] ? 16'hC3A5 : (!read_strobe_n[1] ? 16'h5A3C : noise_r);
endmodule : iprt_drive_model

//--- sim/iprt_properties.sv
`timescale 1ns/1ps
module iprt_checker
  import iprt_pkg::*;
#(
  parameter logic [IPRT_CNT_W-1:0] SAMPLE_CLKS = IPRT_SAMPLE_CLKS,
  parameter logic [IPRT_CNT_W-1:0] RECOV_CLKS  = IPRT_RECOV_CLKS
) (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        RST,
  // Response and bus side
  input wire logic        RSP_VALID,
  input wire logic        RSP_READY,
  input wire logic [15:0] RSP_DATA,
  input wire logic        PRIMARY_CHANNEL_READY,
  input wire logic        SECONDARY_CHANNEL_READY,
  input wire logic [1:0]  READ_STROBE_N,
  input wire logic [1:0]  WRITE_STROBE_N,
  input wire logic        DATA_OE_N
);
  localparam logic [7:0] SMP = {3'h0, SAMPLE_CLKS};
  localparam logic [7:0] RCV = {3'h0, RECOV_CLKS};
  logic       strb_on;
  logic       rdy_sel;
  logic [7:0] low_cnt_r;
  logic [7:0] gap_cnt_r;
  assign strb_on = ~&{READ_STROBE_N, WRITE_STROBE_N};
  assign rdy_sel = (READ_STROBE_N[1] & WRITE_STROBE_N[1]) ? PRIMARY_CHANNEL_READY : SECONDARY_CHANNEL_READY;
  // Gap saturates so a long idle never looks like a short one
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      low_cnt_r <= 8'h00;
      gap_cnt_r <= 8'hFF;
    end else begin
      low_cnt_r <= strb_on ? low_cnt_r + 8'h01 : 8'h00;
      gap_cnt_r <= strb_on ? 8'h00 : ((gap_cnt_r == 8'hFF) ? gap_cnt_r : gap_cnt_r + 8'h01);
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  property p_early_hold; strb_on && low_cnt_r < SMP - 8'h01 |=> strb_on; endproperty
  a_early_hold: assert property (p_early_hold) else $error("strobe ended early");
  property p_ready_ends; strb_on && low_cnt_r >= SMP - 8'h01 && rdy_sel |=> !strb_on; endproperty
  a_ready_ends: assert property (p_ready_ends) else $error("strobe ran past ready");
  property p_wait_ext; strb_on && low_cnt_r >= SMP - 8'h01 && !rdy_sel |=> strb_on; endproperty
  a_wait_ext: assert property (p_wait_ext) else $error("strobe ended while not ready");
  property p_active_min; $fell(strb_on) |-> low_cnt_r >= SMP; endproperty
  a_active_min: assert property (p_active_min) else $error("strobe too short");
  property p_recov; $rose(strb_on) |-> gap_cnt_r >= RCV; endproperty
  a_recov: assert property (p_recov) else $error("recovery too short");
  property p_cycle_len; $rose(RSP_VALID) |-> gap_cnt_r == RCV; endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("cycle length wrong");
  property p_oe_write; !DATA_OE_N |-> WRITE_STROBE_N != 2'b11; endproperty
  a_oe_write: assert property (p_oe_write) else $error("bus driven outside write");
  property p_one_strobe; $onehot0(~{READ_STROBE_N, WRITE_STROBE_N}); endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("two strobes low");
  property p_rsp_hold; RSP_VALID && !RSP_READY |=> RSP_VALID && $stable(RSP_DATA); endproperty
  a_rsp_hold: assert property (p_rsp_hold) else $error("response dropped");
  c_wait: cover property (strb_on && !rdy_sel && low_cnt_r == SMP - 8'h01);
  c_write: cover property (!DATA_OE_N);
  c_stall: cover property (RSP_VALID && !RSP_READY);
endmodule : iprt_checker

//--- sim/iprt_top_tb.sv
`timescale 1ns/1ps
module iprt_top_tb;
  logic CLOCK = 1'b0, RST = 1'b1, REQ_VALID = 1'b0, REQ_WRITE = 1'b0, REQ_CHAN = 1'b0, RSP_READY = 1'b1;
  logic REQ_READY, RSP_VALID, RSP_CHAN, DATA_OE_N, PRIMARY_CHANNEL_READY, SECONDARY_CHANNEL_READY;
  logic [15:0] REQ_DATA = 16'h0000, RSP_DATA, DATA_IN, DATA_OUT;
  logic [1:0]  READ_STROBE_N, WRITE_STROBE_N;
  logic [7:0]  wait_clks = 8'h00;
  int          bad_count = 0, checks_done = 0, len = 0, last_len = 0, rec = 0;
  iprt_top uut (.CLOCK(CLOCK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
    .REQ_WRITE(REQ_WRITE), .REQ_CHAN(REQ_CHAN), .REQ_DATA(REQ_DATA), .RSP_VALID(RSP_VALID),
    .RSP_READY(RSP_READY), .RSP_CHAN(RSP_CHAN), .RSP_DATA(RSP_DATA),
    .PRIMARY_CHANNEL_READY(PRIMARY_CHANNEL_READY), .SECONDARY_CHANNEL_READY(SECONDARY_CHANNEL_READY),
    .READ_STROBE_N(READ_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N), .DATA_IN(DATA_IN),
    .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N));
  iprt_drive_model drive (.clk(CLOCK), .rst(RST), .read_strobe_n(READ_STROBE_N), .write_strobe_n(WRITE_STROBE_N),
    .wait_clks(wait_clks), .pri_rdy(PRIMARY_CHANNEL_READY), .sec_rdy(SECONDARY_CHANNEL_READY), .data_in(DATA_IN));
  initial forever #2 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    if (~&{READ_STROBE_N, WRITE_STROBE_N}) begin
      len <= len + 1;
      rec <= 0;
    end else begin
      rec <= rec + 1;
      if (len != 0) begin
        last_len <= len;
        len <= 0;
      end
    end
  end
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin bad_count++; $display("unexpected %s exp %h got %h", what, exp, got); end
  endtask : chk
  task send(input logic w, input logic ch, input logic [15:0] d);
    REQ_VALID <= 1'b1; REQ_WRITE <= w; REQ_CHAN <= ch; REQ_DATA <= d;
    do @(posedge CLOCK); while (REQ_READY !== 1'b1);
  endtask : send
  task take(input logic ch, input logic [15:0] d);
    int n;
    n = 0;
    do begin @(posedge CLOCK); n++; end while (!(RSP_VALID === 1'b1 && RSP_READY === 1'b1) && n < 400);
    chk("rsp valid", 16'h0001, {15'h0000, RSP_VALID});
    chk("rsp chan", {15'h0000, ch}, {15'h0000, RSP_CHAN});
    chk("rsp data", d, RSP_DATA);
  endtask : take
  task t_read(input logic ch);
    send(1'b0, ch, 16'h0000); REQ_VALID <= 1'b0;
    take(ch, ch ? 16'h5A3C : 16'hC3A5);
    chk("strobe clocks", 16'h0006, last_len[15:0]);
    chk("recovery clocks", 16'h000E, rec[15:0]);
    chk("cycle clocks", 16'h0014, 16'(last_len + rec));
  endtask : t_read
  task t_write(input logic ch, input logic [15:0] d);
    send(1'b1, ch, d); REQ_VALID <= 1'b0;
    @(posedge CLOCK); @(negedge CLOCK);
    chk("write bus", d, DATA_OUT);
    chk("write strobe", {13'h0000, 1'b0, ch ? 2'b01 : 2'b10}, {13'h0000, DATA_OE_N, WRITE_STROBE_N});
    take(ch, d);
  endtask : t_write
  task t_wait(input logic ch, input logic [7:0] w);
    wait_clks <= w; send(1'b0, ch, 16'h0000); REQ_VALID <= 1'b0;
    take(ch, ch ? 16'h5A3C : 16'hC3A5);
    chk("strobe clocks", ((w < 8'h0C) ? 16'h000C : {8'h00, w}) + 16'h0002, last_len[15:0]);
    wait_clks <= 8'h00;
  endtask : t_wait
  task t_stall;
    RSP_READY <= 1'b0;
    send(1'b0, 1'b0, 16'h0000); send(1'b1, 1'b1, 16'h1234); send(1'b0, 1'b1, 16'h0000); REQ_VALID <= 1'b0;
    repeat (40) @(posedge CLOCK);
    @(negedge CLOCK); chk("full and stalled", 16'h0001, {14'h0000, REQ_READY, RSP_VALID});
    @(posedge CLOCK); RSP_READY <= 1'b1;
    take(1'b0, 16'hC3A5); take(1'b1, 16'h1234); take(1'b1, 16'h5A3C);
  endtask : t_stall
  task close_out;
    $display("bad_count %0d checks_done %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    #80000; bad_count++; close_out;
  end
  initial begin
    repeat (6) @(posedge CLOCK);
    RST <= 1'b0;
    @(negedge CLOCK); chk("reset outs", 16'h005F, {9'h000, REQ_READY, RSP_VALID, DATA_OE_N, READ_STROBE_N, WRITE_STROBE_N});
    @(posedge CLOCK);
    t_read(1'b0); t_read(1'b1);
    t_write(1'b1, 16'hA55A); t_write(1'b0, 16'h0F0F);
    t_wait(1'b0, 8'h04); t_wait(1'b1, 8'h14);
    t_stall;
    close_out;
  end
endmodule : iprt_top_tb
bind iprt_top iprt_checker #(.SAMPLE_CLKS(SAMPLE_CLKS), .RECOV_CLKS(RECOV_CLKS)) u_chk (.CLOCK(CLOCK), .RST(RST),
  .RSP_VALID(RSP_VALID), .RSP_READY(RSP_READY), .RSP_DATA(RSP_DATA),
  .PRIMARY_CHANNEL_READY(PRIMARY_CHANNEL_READY), .SECONDARY_CHANNEL_READY(SECONDARY_CHANNEL_READY),
  .READ_STROBE_N(READ_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N), .DATA_OE_N(DATA_OE_N));
